// file: mcm_pkg.sv
/*
 * Constants shared by the motor channel manager: step states, reset-state
 * options and off-time timing.
 * Assumes a 125 MHz clock; timing counts are derived from it.
 */
package mcm_pkg;
    // ==========================================
    // Channel count and field widths
    localparam int NUM_CH = 6;
    localparam int OT_W = 4;
    localparam int CNT_W = 13;

    // ==========================================
    // Clock and off-time timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int PERIPH_FREQ_KHZ = 4000;
    localparam int OFF_STEP_PS = 2500000;
    // Ten peripheral cycles per off-time code step
    localparam int PERIPH_CYC_PER_STEP = OFF_STEP_PS / (1000000000 / PERIPH_FREQ_KHZ);
    // Least time: round the step up to whole clk cycles
    localparam int OFF_STEP_CYCLES = (OFF_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ==========================================
    // Reset-state option encodings
    localparam logic [1:0] RST_HIZ = 2'h0;
    localparam logic [1:0] RST_LOW = 2'h1;
    localparam logic [1:0] RST_HIGH = 2'h2;
    localparam logic [5:0] ZERO6 = 6'h00;

    // ==========================================
    // Step state within one commutation period
    typedef enum logic [1:0] {
        STEP_DEMAG = 2'b00,
        STEP_BEMF = 2'b01,
        STEP_POSTZ = 2'b10
    } mcm_step_e;
endpackage

// file: mcm_out_if.sv
/*
 * Bundle from the channel core to the output stage.
 * Assumes both ends share clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface mcm_out_if;
    logic [5:0] phase;
    logic [5:0] polarity;
    logic [5:0] group;
    logic steerLow;
    logic pwm;
    logic enable;
    logic [1:0] resetSel;
    modport src (output phase, polarity, group, steerLow, pwm, enable, resetSel);
    modport dst (input phase, polarity, group, steerLow, pwm, enable, resetSel);
endinterface
`default_nettype wire

// file: mcm_off_timer.sv
/*
 * Minimum off-time gate for the internal PWM.
 * Assumes pwmRaw is synchronous to clk; stepCycles is at least 1.
 */
`timescale 1ns/1ps
`default_nettype none
module mcm_off_timer #(
    parameter int STEP_CYCLES = mcm_pkg::OFF_STEP_CYCLES
) (
    // Clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // Control
    input wire logic offDisable,
    input wire logic [3:0] minOffTimeCode,
    input wire logic pwmRaw,
    // Result
    output logic pwmGated
);
    logic [12:0] cnt_q, cnt_d;
    logic rawPrev_q, rawPrev_d;
    logic sat_q, sat_d;
    logic gate_q, gate_d;
    logic [12:0] loadVal;

    // ==========================================
    // Off-time counter
    always_comb begin
        loadVal = 13'((32'(minOffTimeCode) + 1) * STEP_CYCLES);
        rawPrev_d = pwmRaw;
        cnt_d = cnt_q;
        sat_d = sat_q;
        // R1 off time select
        if (rawPrev_q && !pwmRaw) begin
            cnt_d = loadVal;
        end else if (cnt_q != 13'h0000) begin
            cnt_d = cnt_q - 13'h0001;
        end
        // R20 period too short
        // A new fall while still counting: period shorter than the off time
        if (rawPrev_q && !pwmRaw && cnt_q > 13'h0001) begin
            sat_d = 1'b1;
        end else if (cnt_q == 13'h0001 && !pwmRaw) begin
            sat_d = 1'b0;
        end
        // R2 no minimum off
        if (offDisable) begin
            cnt_d = 13'h0000;
            sat_d = 1'b0;
        end
        // R3 counted cycles gate
        gate_d = sat_d || (pwmRaw && cnt_d == 13'h0000);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 13'h0000;
            rawPrev_q <= 1'b0;
            sat_q <= 1'b0;
            gate_q <= 1'b0;
        end else if (clkEn) begin
            cnt_q <= cnt_d;
            rawPrev_q <= rawPrev_d;
            sat_q <= sat_d;
            gate_q <= gate_d;
        end
    end

    assign pwmGated = gate_q;
endmodule
`default_nettype wire

// file: mcm_out_stage.sv
/*
 * Output stage: per-channel level and enable, with asynchronous emergency force.
 * Assumes emergencyStop_n may change at any time, clock running or not.
 */
`timescale 1ns/1ps
`default_nettype none
module mcm_out_stage (
    // Clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // From core
    mcm_out_if.dst core,
    input wire logic emergencyStop_n,
    // Pins
    output logic [5:0] motorOutputs,
    output logic [5:0] motorOutputsOe
);
    logic [5:0] lvl_q, lvl_d;
    logic [5:0] oe_q, oe_d;
    logic rstDrive;
    logic rstLevel;

    // R9 reset state option
    assign rstDrive = core.resetSel != mcm_pkg::RST_HIZ;
    assign rstLevel = core.resetSel == mcm_pkg::RST_HIGH;

    // ==========================================
    // Per-channel level
    genvar i;
    for (i = 0; i < mcm_pkg::NUM_CH; i++) begin : g_ch
        logic pwmHere;
        // R11 route to group
        assign pwmHere = core.group[i] == core.steerLow;
        always_comb begin
            // R19 pwm group and step
            // R5 phase and polarity
            if (!core.enable) begin
                lvl_d[i] = rstLevel;
                oe_d[i] = rstDrive;
            end else if (!core.phase[i] || (pwmHere && !core.pwm)) begin
                lvl_d[i] = !core.polarity[i];
                oe_d[i] = 1'b1;
            end else begin
                lvl_d[i] = core.polarity[i];
                oe_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lvl_q <= 6'h00;
            oe_q <= 6'h00;
        end else if (clkEn) begin
            lvl_q <= lvl_d;
            oe_q <= oe_d;
        end
    end

    // R15 asynchronous emergency force
    // R18 no clock needed
    assign motorOutputs = emergencyStop_n ? lvl_q : {6{rstLevel}};
    assign motorOutputsOe = emergencyStop_n ? oe_q : {6{rstDrive}};
endmodule
`default_nettype wire

// file: mcm_channel_manager.sv
/*
 * Motor channel manager top: phase state with preload, polarity and group
 * maps, step tracking, PWM steering, minimum off time and emergency stop.
 * Assumes control bits and events are synchronous to clk; emergencyStop_n
 * alone is asynchronous.
 */
// Overview of operation
// R1 - Off-time code picks 2.5 to 40 us minimum off, in 2.5 us steps.
// R2 - Sensor mode or sampling during ON forces minimum off time to zero.
// R3 - Off time is timed by counting clock cycles per code step.
// R4 - Preload value moves into the phase register only on a commutation event.
// R5 - Phase 0 drives inverse polarity; phase 1 drives polarity with PWM allowed.
// R6 - Direct access writes phase directly and each write makes a commutation event.
// R7 - In direct access the post-zero steering bit alone picks PWM routing.
// R8 - Enable low gives reset state; high gives normal or direct-access operation.
// R9 - Reset state is high impedance, low or high by option setting.
// R10 - Group bit 0 puts output in high group, 1 in low group.
// R11 - Multiplexer routes PWM to high or low group by step state.
// R12 - Demag steering bit is preloaded and becomes active at commutation.
// R13 - Bemf steering bit routes PWM between demag-end and zero-crossing.
// R14 - Post-zero steering bit routes PWM from zero-crossing to next commutation.
// R15 - Emergency low forces outputs into reset state without a clock.
// R16 - Emergency clears the main output enable until software sets it.
// R17 - Emergency raises an interrupt request only when its mask is set.
// R18 - Emergency shutdown works with the oscillator stopped.
// R19 - Output level depends on PWM, group and step as well as phase.
// R20 - Off time longer than PWM period gives constant high PWM.
`timescale 1ns/1ps
`default_nettype none
module mcm_channel_manager #(
    parameter int OFF_STEP_CYCLES = mcm_pkg::OFF_STEP_CYCLES
) (
    // Clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // Mode and off-time control
    input wire logic sensorModeSelect,
    input wire logic sampleDuringOnEnable,
    input wire logic [3:0] onTimeSampleDelay,
    input wire logic [3:0] minOffTimeCode,
    // Phase state, polarity and groups
    input wire logic [5:0] outputStatePreload,
    input wire logic preloadWrite,
    input wire logic [5:0] outputPolarityBits,
    input wire logic [5:0] groupAssign,
    input wire logic directAccess,
    input wire logic mainOutputEnableSet,
    // PWM steering
    input wire logic demagPwmSteer,
    input wire logic bemfPwmSteer,
    input wire logic postZeroPwmSteer,
    // Events and internal PWM
    input wire logic commEvent,
    input wire logic demagEndEvent,
    input wire logic zeroCrossEvent,
    input wire logic pwmRaw,
    // Emergency and option
    input wire logic emergencyStop_n,
    input wire logic emergencyIrqMask,
    input wire logic [1:0] resetStateOption,
    // Pins
    output logic [5:0] motorOutputs,
    output logic [5:0] motorOutputsOe,
    // Status
    output logic mainOutputEnable,
    output logic [5:0] phaseState,
    output logic [1:0] stepState,
    output logic emergencyIrq
);
    mcm_out_if outBus ();

    // ==========================================
    // State registers
    logic [5:0] preload_q, preload_d;
    logic [5:0] phase_q, phase_d;
    logic demagSteer_q, demagSteer_d;
    mcm_pkg::mcm_step_e step_q, step_d;
    logic steerLow_q, steerLow_d;
    logic moe_q, moe_d;
    logic [1:0] opt_q, opt_d;
    logic optTaken_q, optTaken_d;
    logic stopSync1_q, stopSync2_q, stopPrev_q;
    logic irq_q, irq_d;
    logic commNow;
    logic offDisable;
    logic pwmGated;

    // R6 write makes commutation
    assign commNow = commEvent || (directAccess && preloadWrite);
    // R2 no minimum off
    assign offDisable = sensorModeSelect || sampleDuringOnEnable
        || onTimeSampleDelay != 4'h0;

    // ==========================================
    // Phase register, preload and step tracking
    always_comb begin
        preload_d = preloadWrite ? outputStatePreload : preload_q;
        phase_d = phase_q;
        demagSteer_d = demagSteer_q;
        step_d = step_q;
        // R4 preload on commutation
        // R6 direct write path
        if (commNow) begin
            phase_d = preloadWrite ? outputStatePreload : preload_q;
        end
        // R12 demag bit preload
        if (commNow) begin
            demagSteer_d = demagPwmSteer;
        end
        case (step_q)
            mcm_pkg::STEP_DEMAG: begin
                if (demagEndEvent) begin
                    step_d = mcm_pkg::STEP_BEMF;
                end
            end
            mcm_pkg::STEP_BEMF: begin
                if (zeroCrossEvent) begin
                    step_d = mcm_pkg::STEP_POSTZ;
                end
            end
            mcm_pkg::STEP_POSTZ: begin
                step_d = step_q;
            end
            default: begin
                step_d = mcm_pkg::STEP_DEMAG;
            end
        endcase
        // Commutation restarts the step sequence from any state
        if (commNow) begin
            step_d = mcm_pkg::STEP_DEMAG;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            preload_q <= 6'h00;
            phase_q <= 6'h00;
            demagSteer_q <= 1'b0;
            step_q <= mcm_pkg::STEP_DEMAG;
        end else if (clkEn) begin
            preload_q <= preload_d;
            phase_q <= phase_d;
            demagSteer_q <= demagSteer_d;
            step_q <= step_d;
        end
    end

    // ==========================================
    // PWM steering multiplexer select
    always_comb begin
        case (step_q)
            // R12 demag interval
            mcm_pkg::STEP_DEMAG: steerLow_d = demagSteer_q;
            // R13 bemf interval
            mcm_pkg::STEP_BEMF: steerLow_d = bemfPwmSteer;
            // R14 after zero crossing
            mcm_pkg::STEP_POSTZ: steerLow_d = postZeroPwmSteer;
            default: steerLow_d = postZeroPwmSteer;
        endcase
        // R7 direct access steering
        if (directAccess) begin
            steerLow_d = postZeroPwmSteer;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            steerLow_q <= 1'b0;
        end else if (clkEn) begin
            steerLow_q <= steerLow_d;
        end
    end

    // ==========================================
    // Main output enable; emergency clears it without a clock
    always_comb begin
        moe_d = moe_q || mainOutputEnableSet;
    end

    // R16 emergency clears enable
    always_ff @(posedge clk or posedge rst or negedge emergencyStop_n) begin
        if (rst) begin
            moe_q <= 1'b0;
        end else if (!emergencyStop_n) begin
            moe_q <= 1'b0;
        end else if (clkEn) begin
            moe_q <= moe_d;
        end
    end

    // ==========================================
    // Reset-state option, caught once after reset release like a strap
    always_comb begin
        opt_d = optTaken_q ? opt_q : resetStateOption;
        optTaken_d = 1'b1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opt_q <= mcm_pkg::RST_HIZ;
            optTaken_q <= 1'b0;
        end else if (clkEn) begin
            opt_q <= opt_d;
            optTaken_q <= optTaken_d;
        end
    end

    // ==========================================
    // Emergency interrupt: synchronise, detect the falling edge
    always_comb begin
        // R17 masked request
        irq_d = stopPrev_q && !stopSync2_q && emergencyIrqMask;
    end

    // Synchroniser stages stay free of clkEn so a stop that is still low when clkEn returns is not missed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stopSync1_q <= 1'b1;
            stopSync2_q <= 1'b1;
        end else begin
            stopSync1_q <= emergencyStop_n;
            stopSync2_q <= stopSync1_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stopPrev_q <= 1'b1;
            irq_q <= 1'b0;
        end else if (clkEn) begin
            stopPrev_q <= stopSync2_q;
            irq_q <= irq_d;
        end
    end

    // ==========================================
    // Sub-blocks
    mcm_off_timer #(
        .STEP_CYCLES(OFF_STEP_CYCLES)
    ) u_off (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .offDisable(offDisable),
        .minOffTimeCode(minOffTimeCode),
        .pwmRaw(pwmRaw),
        .pwmGated(pwmGated)
    );

    // R8 enable gates outputs
    // R10 group map passed on
    assign outBus.phase = phase_q;
    assign outBus.polarity = outputPolarityBits;
    assign outBus.group = groupAssign;
    assign outBus.steerLow = steerLow_q;
    assign outBus.pwm = pwmGated;
    assign outBus.enable = moe_q;
    assign outBus.resetSel = opt_q;

    mcm_out_stage u_out (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .core(outBus.dst),
        .emergencyStop_n(emergencyStop_n),
        .motorOutputs(motorOutputs),
        .motorOutputsOe(motorOutputsOe)
    );

    assign mainOutputEnable = moe_q;
    assign phaseState = phase_q;
    assign stepState = step_q;
    assign emergencyIrq = irq_q;

    // ==========================================
    // Assertions
    sequence s_commWrite;
        clkEn && commNow && !preloadWrite;
    endsequence

    property p_preload_on_comm;
        @(posedge clk) disable iff (rst)
        s_commWrite |=> phase_q == $past(preload_q);
    endproperty
    a_preload_on_comm: assert property (p_preload_on_comm) // R4
        else $error("phase not loaded from preload");

    property p_phase_holds;
        @(posedge clk) disable iff (rst)
        !commNow |=> $stable(phase_q);
    endproperty
    a_phase_holds: assert property (p_phase_holds) // R4
        else $error("phase changed without commutation");

    property p_direct_write;
        @(posedge clk) disable iff (rst)
        clkEn && directAccess && preloadWrite |=> phase_q == $past(outputStatePreload)
            && step_q == mcm_pkg::STEP_DEMAG;
    endproperty
    a_direct_write: assert property (p_direct_write) // R6
        else $error("direct write did not commutate");

    property p_direct_steer;
        @(posedge clk) disable iff (rst)
        clkEn && directAccess |=> steerLow_q == $past(postZeroPwmSteer);
    endproperty
    a_direct_steer: assert property (p_direct_steer) // R7
        else $error("direct access steering wrong");

    sequence s_enterBemf;
        clkEn && step_q == mcm_pkg::STEP_DEMAG && demagEndEvent && !commNow;
    endsequence

    property p_bemf_steer;
        @(posedge clk) disable iff (rst)
        s_enterBemf ##1 (clkEn && !directAccess && !commNow && !zeroCrossEvent)
            |=> steerLow_q == $past(bemfPwmSteer);
    endproperty
    a_bemf_steer: assert property (p_bemf_steer) // R13
        else $error("bemf steering wrong");

    property p_demag_latched;
        @(posedge clk) disable iff (rst)
        clkEn && commNow |=> demagSteer_q == $past(demagPwmSteer);
    endproperty
    a_demag_latched: assert property (p_demag_latched) // R12
        else $error("demag steering not latched");

    property p_emerg_moe;
        @(posedge clk) disable iff (rst)
        !emergencyStop_n |-> !moe_q;
    endproperty
    a_emerg_moe: assert property (p_emerg_moe) // R16
        else $error("enable not cleared by emergency");

    property p_emerg_pins;
        @(posedge clk) disable iff (rst)
        !emergencyStop_n |-> motorOutputsOe == {6{opt_q != mcm_pkg::RST_HIZ}};
    endproperty
    a_emerg_pins: assert property (p_emerg_pins) // R15
        else $error("pins not in reset state");

    property p_irq_mask;
        @(posedge clk) disable iff (rst)
        emergencyIrq |-> $past(emergencyIrqMask) && !$past(stopSync2_q);
    endproperty
    a_irq_mask: assert property (p_irq_mask) // R17
        else $error("unmasked emergency irq");

    property p_moe_off_reset_state;
        @(posedge clk) disable iff (rst)
        clkEn && !moe_q && emergencyStop_n ##1 emergencyStop_n
            |-> motorOutputsOe == {6{$past(opt_q) != mcm_pkg::RST_HIZ}};
    endproperty
    a_moe_off_reset_state: assert property (p_moe_off_reset_state) // R8
        else $error("outputs not in reset state");

    property p_no_off_sensor;
        @(posedge clk) disable iff (rst)
        clkEn && offDisable && pwmRaw ##1 (clkEn && offDisable && pwmRaw) |-> pwmGated;
    endproperty
    a_no_off_sensor: assert property (p_no_off_sensor) // R2
        else $error("off time applied in sensor mode");
endmodule
`default_nettype wire

// file: mcm_gate_driver_model.sv
/*
 * Behavioural model of the external power switch gate drivers.
 * Assumes the bench raises alarm to mimic a driver fault signal.
 */
`timescale 1ns/1ps
`default_nettype none
module mcm_gate_driver_model (
    // Pins from the channel manager
    input wire logic [5:0] motorOutputs,
    input wire logic [5:0] motorOutputsOe,
    // Fault command from the bench
    input wire logic alarm,
    // Seen by the device and the bench
    output logic emergencyStop_n,
    output logic [5:0] gateLevel
);
    // ==========================================
    // Gate inputs
    // pull-down on released pins
    // A pin that is not driven reads 0, never the last driven value
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            gateLevel[i] = motorOutputsOe[i] ? motorOutputs[i] : 1'b0;
        end
    end

    assign emergencyStop_n = !alarm; // Pulled up while no fault
endmodule
`default_nettype wire

// file: motor_channel_manager_test.sv
/*
 * Self-checking bench for the motor channel manager.
 * Assumes a shortened off-time step so minimum off counts stay brief.
 */
`timescale 1ns/1ps
`default_nettype none
module motor_channel_manager_test;
    localparam int STEP = 2;
    logic clk = 1'b0;
    logic clkRun = 1'b1;
    logic rst = 1'b1;
    logic sensorModeSelect = 1'b0, sampleDuringOnEnable = 1'b0;
    logic [3:0] onTimeSampleDelay = 4'h0, minOffTimeCode = 4'h0;
    logic [5:0] outputStatePreload = 6'h00, outputPolarityBits = 6'h00, groupAssign = 6'h00;
    logic preloadWrite = 1'b0, directAccess = 1'b0, mainOutputEnableSet = 1'b0;
    logic demagPwmSteer = 1'b0, bemfPwmSteer = 1'b0, postZeroPwmSteer = 1'b0;
    logic commEvent = 1'b0, demagEndEvent = 1'b0, zeroCrossEvent = 1'b0, pwmRaw = 1'b1;
    logic emergencyIrqMask = 1'b0, alarm = 1'b0;
    logic [1:0] resetStateOption = 2'h0;
    logic emergencyStop_n, mainOutputEnable, emergencyIrq;
    logic [5:0] motorOutputs, motorOutputsOe, phaseState, gateLevel, pol, grp, pre;
    logic [1:0] stepState;
    logic [2:0] st;
    int err_count = 0, check_count = 0, n;

    // ==========================================
    // Clock, design and far side
    always #4 if (clkRun) clk = ~clk; // Stops only for the oscillator-off case

    mcm_channel_manager #(.OFF_STEP_CYCLES(STEP)) dut_u (.clk(clk), .rst(rst), .clkEn(1'b1),
        .sensorModeSelect(sensorModeSelect), .sampleDuringOnEnable(sampleDuringOnEnable),
        .onTimeSampleDelay(onTimeSampleDelay), .minOffTimeCode(minOffTimeCode),
        .outputStatePreload(outputStatePreload), .preloadWrite(preloadWrite),
        .outputPolarityBits(outputPolarityBits), .groupAssign(groupAssign),
        .directAccess(directAccess), .mainOutputEnableSet(mainOutputEnableSet),
        .demagPwmSteer(demagPwmSteer), .bemfPwmSteer(bemfPwmSteer),
        .postZeroPwmSteer(postZeroPwmSteer), .commEvent(commEvent),
        .demagEndEvent(demagEndEvent), .zeroCrossEvent(zeroCrossEvent), .pwmRaw(pwmRaw),
        .emergencyStop_n(emergencyStop_n), .emergencyIrqMask(emergencyIrqMask),
        .resetStateOption(resetStateOption), .motorOutputs(motorOutputs),
        .motorOutputsOe(motorOutputsOe), .mainOutputEnable(mainOutputEnable),
        .phaseState(phaseState), .stepState(stepState), .emergencyIrq(emergencyIrq));

    mcm_gate_driver_model gate_u (.motorOutputs(motorOutputs), .motorOutputsOe(motorOutputsOe),
        .alarm(alarm), .emergencyStop_n(emergencyStop_n), .gateLevel(gateLevel));

    // ==========================================
    // Helpers
    // Inputs set after tick move 1 ns after the edge, away from sampling
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [11:0] expv, input logic [11:0] gotv);
        check_count++;
        if (gotv !== expv) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, expv, gotv);
        end
    endtask

    // One-cycle pulse: 0 comm, 1 demag end, 2 zero cross, 3 write, 4 enable set
    task automatic ev(input int k);
        case (k)
            0: commEvent = 1'b1;
            1: demagEndEvent = 1'b1;
            2: zeroCrossEvent = 1'b1;
            3: preloadWrite = 1'b1;
            default: mainOutputEnableSet = 1'b1;
        endcase
        tick(1);
        {commEvent, demagEndEvent, zeroCrossEvent, preloadWrite, mainOutputEnableSet} = 5'h00;
    endtask

    task automatic doReset(input logic [1:0] opt);
        rst = 1'b1;
        resetStateOption = opt;
        tick(10);
        rst = 1'b0;
        tick(3);
    endtask

    // Expected pin levels with outputs enabled
    function automatic logic [5:0] expPins(input logic [5:0] ph, input logic [5:0] pl,
                                           input logic [5:0] gr, input logic steer,
                                           input logic pwm);
        for (int i = 0; i < 6; i++) begin
            expPins[i] = (ph[i] && !((gr[i] == steer) && !pwm)) ? pl[i] : !pl[i];
        end
    endfunction

    // Count low cycles after a one-cycle dip of the raw PWM
    task automatic offDip(output int cnt);
        tick(40);
        pwmRaw = 1'b0;
        tick(1);
        pwmRaw = 1'b1;
        cnt = 0;
        repeat (60) begin
            tick(1);
            if (motorOutputs === 6'h00) cnt++;
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================
    // Watchdog: the whole run needs well under 200 us
    initial begin
        #200000;
        err_count++;
        results();
    end

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'h1769));
        for (int o = 0; o < 3; o++) begin
            doReset(o[1:0]);
            check("reset pins", {(o == 0) ? 6'h00 : 6'h3F, (o == 2) ? 6'h3F : 6'h00},
                  {motorOutputsOe, gateLevel});
            check("reset enable", 12'h000, {11'h000, mainOutputEnable});
        end
        ev(4);
        // Preload, steps and steering with random maps
        repeat (20) begin
            pol = 6'($urandom);
            grp = 6'($urandom);
            pre = 6'($urandom);
            st = 3'($urandom);
            pwmRaw = 1'($urandom);
            {outputPolarityBits, groupAssign, outputStatePreload} = {pol, grp, pre};
            {demagPwmSteer, bemfPwmSteer, postZeroPwmSteer} = st;
            n = phaseState;
            ev(3);
            tick(3);
            check("phase held", 12'(n), {6'h00, phaseState});
            ev(0);
            demagPwmSteer = !st[2];
            tick(3);
            check("phase comm", {4'h0, 2'h0, pre}, {4'h0, stepState, phaseState});
            check("demag pins", {6'h3F, expPins(pre, pol, grp, st[2], pwmRaw)},
                  {motorOutputsOe, motorOutputs});
            ev(1);
            tick(3);
            check("bemf pins", {4'h0, 2'h1, expPins(pre, pol, grp, st[1], pwmRaw)},
                  {4'h0, stepState, motorOutputs});
            ev(2);
            tick(3);
            check("postz pins", {4'h0, 2'h2, expPins(pre, pol, grp, st[0], pwmRaw)},
                  {4'h0, stepState, motorOutputs});
        end
        // Direct access: each write is a commutation, post-zero steer alone
        directAccess = 1'b1;
        pwmRaw = 1'b0;
        repeat (8) begin
            pre = 6'($urandom);
            postZeroPwmSteer = 1'($urandom);
            {demagPwmSteer, bemfPwmSteer} = {2{!postZeroPwmSteer}};
            outputStatePreload = pre;
            ev(3);
            tick(3);
            check("direct phase", {4'h0, 2'h0, pre}, {4'h0, stepState, phaseState});
            check("direct pins", {6'h00, expPins(pre, pol, grp, postZeroPwmSteer, 1'b0)},
                  {6'h00, motorOutputs});
        end
        // Minimum off time: all outputs in the high group, PWM routed there
        {outputPolarityBits, groupAssign, outputStatePreload, postZeroPwmSteer} = 19'h7E07E;
        pwmRaw = 1'b1;
        ev(3);
        for (int i = 0; i < 3; i++) begin
            minOffTimeCode = (i == 0) ? 4'h0 : ((i == 1) ? 4'h5 : 4'hF);
            offDip(n);
            check("off count", 12'((minOffTimeCode + 1) * STEP), 12'(n));
        end
        for (int m = 1; m < 4; m++) begin
            {sensorModeSelect, sampleDuringOnEnable} = {m == 1, m == 2};
            onTimeSampleDelay = (m == 3) ? 4'(1 + $urandom % 15) : 4'h0;
            offDip(n);
            check("no min off", 12'h001, 12'(n));
        end
        // Emergency stop, with and without the interrupt mask
        outputPolarityBits = 6'h00;
        for (int m = 0; m < 2; m++) begin
            emergencyIrqMask = m[0];
            tick(3);
            #2 alarm = 1'b1;
            #1 check("emerg pins", 12'hFFF, {motorOutputsOe, motorOutputs});
            check("emerg enable", 12'h000, {11'h000, mainOutputEnable});
            n = 0;
            repeat (8) begin
                tick(1);
                if (emergencyIrq === 1'b1) n++;
            end
            check("irq count", 12'(m), 12'(n));
            alarm = 1'b0;
            tick(4);
            check("enable stays off", 12'h000, {11'h000, mainOutputEnable});
            ev(4);
            tick(1);
            check("enable again", 12'h001, {11'h000, mainOutputEnable});
        end
        // Oscillator stopped: the force must still reach the pins
        tick(3);
        clkRun = 1'b0;
        #20 alarm = 1'b1;
        #2 check("stopped clock pins", 12'hFFF, {motorOutputsOe, motorOutputs});
        alarm = 1'b0;
        clkRun = 1'b1;
        tick(4);
        results();
    end
endmodule
`default_nettype wire
